// ==== pfg_port_f_gpio.sv ====
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
module pfg_port_f_gpio
(
  input  wire logic                      clock,
  input  wire logic                      arst_n,
  input  wire logic [4:0]                address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  input  wire logic [3:0]                byteenable,
  output logic      [31:0]               readdata,
  output logic      [1:0]                response,
  output logic                           waitrequest,
  input  wire logic [2:0]                modePins,
  input  wire pfg_pkg::pfg_strobes_t     busStrobes,
  input  wire pfg_pkg::pfg_bus_select_t  busSelect,
  input  wire logic [7:0]                pinIn,
  output logic      [7:0]                pinOut,
  output logic      [7:0]                pinOutEn_n,
  output logic                           busWait_n
);

  pfg_pkg::pfg_bus_state_t state;
  pfg_pkg::pfg_bus_state_t next_state;

  logic [7:0]  direction;
  logic [7:0]  outputData;
  logic [4:0]  control;
  logic [2:0]  mode;
  logic        modeValid;
  logic [1:0]  settleCount;
  logic [7:0]  pinSync;
  logic [2:0]  modeSync;
  logic        modeExternal;
  logic        expanded;
  logic [7:0]  pinState;
  logic [7:0]  muxValue;
  logic [7:0]  muxDrive;
  logic        waitActive;
  logic        takeRequest;
  logic        commitWrite;
  logic        lowLane;
  logic        hitDirection;
  logic        hitOutputData;
  logic        hitPinState;
  logic        hitControl;
  logic        hitModeStatus;
  logic        hitAny;
  logic [31:0] next_readdata;
  logic [1:0]  next_response;
  pfg_pkg::pfg_ctrl_t ctrlFields;

  // pin and strap levels come from outside; two stages before any use
  pfg_sync2
  #(
    .WIDTH (8)
  )
  u_pin_sync
  (
    .clock  (clock),
    .arst_n (arst_n),
    .async  (pinIn),
    .synced (pinSync)
  );

  pfg_sync2
  #(
    .WIDTH (3)
  )
  u_mode_sync
  (
    .clock  (clock),
    .arst_n (arst_n),
    .async  (modePins),
    .synced (modeSync)
  );

  // strap capture: wait for the synchroniser to fill, then freeze the mode
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      settleCount <= 2'h0;
      modeValid   <= 1'b0;
      mode        <= 3'h0;
    end
    else if (!modeValid)
    begin
      if (settleCount == pfg_pkg::STRAP_SETTLE)
      begin
        modeValid <= 1'b1;
        mode      <= modeSync;
      end
      else
      begin
        settleCount <= settleCount + 2'h1;
      end
    end
  end

  assign modeExternal = (mode == pfg_pkg::MODE_1) || (mode == pfg_pkg::MODE_2) ||
                        (mode == pfg_pkg::MODE_4);
  // pins stay plain I/O until the mode is known, which avoids glitching strobes
  assign expanded = modeValid &&
                    (modeExternal ||
                     ((mode == pfg_pkg::MODE_7) &&
                      control[pfg_pkg::CTRL_EXPANSION_BIT]));

  assign ctrlFields.externalExpansionEnable = control[pfg_pkg::CTRL_EXPANSION_BIT];
  assign ctrlFields.addrStrobeOutEnable     = control[pfg_pkg::CTRL_ADDR_STROBE_BIT];
  assign ctrlFields.lowWriteOutEnable       = control[pfg_pkg::CTRL_LOW_WRITE_BIT];
  assign ctrlFields.chipSelect6Enable       = control[pfg_pkg::CTRL_CHIP_SEL6_BIT];
  assign ctrlFields.chipSelect5Enable       = control[pfg_pkg::CTRL_CHIP_SEL5_BIT];

  // address decode
  assign hitDirection  = (address == pfg_pkg::OFFSET_DIRECTION);
  assign hitOutputData = (address == pfg_pkg::OFFSET_OUTPUT_DATA);
  assign hitPinState   = (address == pfg_pkg::OFFSET_PIN_STATE);
  assign hitControl    = (address == pfg_pkg::OFFSET_CONTROL);
  assign hitModeStatus = (address == pfg_pkg::OFFSET_MODE_STATUS);
  assign hitAny        = hitDirection | hitOutputData | hitPinState |
                         hitControl | hitModeStatus;
  assign lowLane       = byteenable[0];

  assign takeRequest = (state == pfg_pkg::ST_IDLE) && (read || write);
  // a write lands at the edge where waitrequest is seen low
  assign commitWrite = (state == pfg_pkg::ST_ANSWER) && write && lowLane;

  // one wait cycle per access, so read data are registered before release
  always_comb
  begin
    next_state = state;
    unique case (state)
      pfg_pkg::ST_IDLE:
      begin
        if (read || write)
        begin
          next_state = pfg_pkg::ST_ANSWER;
        end
      end
      pfg_pkg::ST_ANSWER:
      begin
        next_state = pfg_pkg::ST_IDLE;
      end
      default:
      begin
        next_state = pfg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= pfg_pkg::ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign waitrequest = (read || write) && (state != pfg_pkg::ST_ANSWER);

  // direction register
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      direction <= pfg_pkg::DIRECTION_RESET;
    end
    else if (!modeValid && (settleCount == pfg_pkg::STRAP_SETTLE))
    begin
      // pin 7 default depends on the strap, so it is set once at capture
      direction[7] <= (modeSync == pfg_pkg::MODE_1) ||
                      (modeSync == pfg_pkg::MODE_2) ||
                      (modeSync == pfg_pkg::MODE_4);
    end
    else if (commitWrite && hitDirection)
    begin
      direction <= writedata[7:0];
    end
  end

  // output data register
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      outputData <= pfg_pkg::OUTPUT_DATA_RESET;
    end
    else if (commitWrite && hitOutputData)
    begin
      outputData <= writedata[7:0];
    end
  end

  // pin-function control bits
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      control <= pfg_pkg::CONTROL_RESET;
    end
    else if (commitWrite && hitControl)
    begin
      control <= writedata[4:0];
    end
  end

  // output bits read back as written, input bits as the synced pin
  assign pinState = (direction & outputData) | (~direction & pinSync);

  always_comb
  begin
    next_readdata = 32'h0000_0000;
    next_response = pfg_pkg::RESP_OKAY;
    if (hitDirection)
    begin
      next_readdata[7:0] = pfg_pkg::DIRECTION_FILLER;
    end
    else if (hitOutputData)
    begin
      next_readdata[7:0] = outputData;
    end
    else if (hitPinState)
    begin
      // writes here are accepted and dropped
      next_readdata[7:0] = pinState;
    end
    else if (hitControl)
    begin
      next_readdata[4:0] = control;
    end
    else if (hitModeStatus)
    begin
      next_readdata[pfg_pkg::STATUS_MODE_LSB +: 3] = mode;
      next_readdata[pfg_pkg::STATUS_VALID_BIT]     = modeValid;
    end
    if (!hitAny)
    begin
      next_response = pfg_pkg::RESP_SLAVE_ERR;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      readdata <= 32'h0000_0000;
      response <= pfg_pkg::RESP_OKAY;
    end
    else if (takeRequest)
    begin
      readdata <= read ? next_readdata : 32'h0000_0000;
      response <= next_response;
    end
  end

  pfg_pin_mux u_pin_mux
  (
    .expanded   (expanded),
    .direction  (direction),
    .outputData (outputData),
    .ctrl       (ctrlFields),
    .strobes    (busStrobes),
    .busSelect  (busSelect),
    .pinValue   (muxValue),
    .pinDrive   (muxDrive),
    .waitActive (waitActive)
  );

  // pin drivers are registered; strobes reach the pins one cycle late
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinOut     <= 8'h00;
      pinOutEn_n <= 8'hff;
    end
    else
    begin
      pinOut     <= muxValue;
      pinOutEn_n <= ~muxDrive;
    end
  end

  // wait is active low, held inactive when the wait function is off
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busWait_n <= 1'b1;
    end
    else
    begin
      busWait_n <= waitActive ? pinSync[0] : 1'b1;
    end
  end

endmodule

// ==== pfg_pkg.sv ====
// Function
// - The direction register is write-only and a read of it returns a fixed filler value, never the stored bits.
// - After reset pin 7 direction is 1 in modes 1, 2 and 4 and 0 in mode 7, all other direction bits are 0.
// - Pin 7 drives the system clock when its direction bit is 1 and is an input when it is 0, in every mode.
// - In expanded operation pin 6 drives the address strobe when its enable is 1, else it is direction-steered I/O.
// - In expanded operation pins 5 and 4 drive the read and high-byte write strobes whatever their direction bits.
// - In expanded operation pin 3 drives the low-byte write strobe when its enable is 1, else direction-steered I/O.
// - In expanded operation pins 2 and 1 drive the column strobes when selected, else chip selects 6 and 5 when enabled, else I/O.
// - In expanded operation pin 0 is the bus wait input when waiting is enabled, else direction-steered I/O.
// - In mode 7 with expansion off, pins 6 to 0 are plain I/O steered only by their direction bits.
// - The output data register is read-write, resets to zero and drives the pins set up as general outputs.
// - A pin-state read returns output data where the direction bit is 1 and the pin level where it is 0; writes are ignored.
package pfg_pkg;

  localparam int ADDR_W = 5;

  localparam logic [4:0] OFFSET_DIRECTION   = 5'h00;
  localparam logic [4:0] OFFSET_OUTPUT_DATA = 5'h04;
  localparam logic [4:0] OFFSET_PIN_STATE   = 5'h08;
  localparam logic [4:0] OFFSET_CONTROL     = 5'h0c;
  localparam logic [4:0] OFFSET_MODE_STATUS = 5'h10;

  localparam int CTRL_EXPANSION_BIT   = 0;
  localparam int CTRL_ADDR_STROBE_BIT = 1;
  localparam int CTRL_LOW_WRITE_BIT   = 2;
  localparam int CTRL_CHIP_SEL6_BIT   = 3;
  localparam int CTRL_CHIP_SEL5_BIT   = 4;

  localparam int STATUS_MODE_LSB   = 0;
  localparam int STATUS_VALID_BIT  = 3;

  localparam logic [7:0] DIRECTION_RESET   = 8'h00;
  localparam logic [7:0] OUTPUT_DATA_RESET = 8'h00;
  localparam logic [4:0] CONTROL_RESET     = 5'h06;
  localparam logic [7:0] DIRECTION_FILLER  = 8'h00;

  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_7 = 3'h7;

  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLAVE_ERR = 2'h2;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b01,
    ST_ANSWER = 2'b10
  } pfg_bus_state_t;

  typedef struct packed
  {
    logic sysClockOut;
    logic addressStrobe;
    logic readStrobe;
    logic highByteWriteStrobe;
    logic lowByteWriteStrobe;
    logic lowerColumnStrobe;
    logic upperColumnStrobe;
    logic chipSelect6;
    logic chipSelect5;
  } pfg_strobes_t;

  typedef struct packed
  {
    logic columnStrobeSelect;
    logic waitEnable;
  } pfg_bus_select_t;

  typedef struct packed
  {
    logic externalExpansionEnable;
    logic addrStrobeOutEnable;
    logic lowWriteOutEnable;
    logic chipSelect6Enable;
    logic chipSelect5Enable;
  } pfg_ctrl_t;

endpackage

// ==== pfg_sync2.sv ====
`timescale 1ns/10ps
module pfg_sync2
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second one
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= '0;
      synced <= '0;
    end
    else
    begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule

// ==== pfg_pin_mux.sv ====
`timescale 1ns/10ps
module pfg_pin_mux
(
  input  wire logic                      expanded,
  input  wire logic [7:0]                direction,
  input  wire logic [7:0]                outputData,
  input  wire pfg_pkg::pfg_ctrl_t        ctrl,
  input  wire pfg_pkg::pfg_strobes_t     strobes,
  input  wire pfg_pkg::pfg_bus_select_t  busSelect,
  output logic      [7:0]                pinValue,
  output logic      [7:0]                pinDrive,
  output logic                           waitActive
);

  logic [7:0] altActive;
  logic [7:0] altValue;
  logic [7:0] altDrive;

  always_comb
  begin
    altActive = 8'h00;
    altValue  = 8'h00;
    altDrive  = 8'h00;
    waitActive = 1'b0;
    // clock output follows the direction bit alone
    altActive[7] = direction[7];
    altValue[7]  = strobes.sysClockOut;
    altDrive[7]  = 1'b1;
    // with expansion off every alternate function below stays idle
    if (expanded)
    begin
      altActive[6] = ctrl.addrStrobeOutEnable;
      altValue[6]  = strobes.addressStrobe;
      altActive[5] = 1'b1;
      altValue[5]  = strobes.readStrobe;
      altActive[4] = 1'b1;
      altValue[4]  = strobes.highByteWriteStrobe;
      altActive[3] = ctrl.lowWriteOutEnable;
      altValue[3]  = strobes.lowByteWriteStrobe;
      altActive[2] = busSelect.columnStrobeSelect | ctrl.chipSelect6Enable;
      altValue[2]  = busSelect.columnStrobeSelect ? strobes.lowerColumnStrobe
                                                  : strobes.chipSelect6;
      altActive[1] = busSelect.columnStrobeSelect | ctrl.chipSelect5Enable;
      altValue[1]  = busSelect.columnStrobeSelect ? strobes.upperColumnStrobe
                                                  : strobes.chipSelect5;
      altActive[0] = busSelect.waitEnable;
      waitActive   = busSelect.waitEnable;
      altDrive[6:1] = 6'h3f;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      // general I/O falls back on direction and output data
      assign pinDrive[i] = altActive[i] ? altDrive[i] : direction[i];
      assign pinValue[i] = altActive[i] ? altValue[i] : outputData[i];
    end
  endgenerate

endmodule

// ==== pfg_port_f_gpio_asserts.sv ====
`timescale 1ns/10ps
module pfg_port_f_gpio_asserts
(
  input wire logic                     clock,
  input wire logic                     arst_n,
  input wire logic [4:0]               address,
  input wire logic                     read,
  input wire logic                     write,
  input wire logic [31:0]              readdata,
  input wire logic [1:0]               response,
  input wire logic                     waitrequest,
  input wire logic [2:0]               modePins,
  input wire pfg_pkg::pfg_strobes_t    busStrobes,
  input wire pfg_pkg::pfg_bus_select_t busSelect,
  input wire logic [7:0]               pinOut,
  input wire logic [7:0]               pinOutEn_n,
  input wire logic                     busWait_n
);
  logic [3:0] postRst;
  logic       is124;
  logic       busMode;
  // the strap only changes while reset is held, so it stands in for the captured mode
  assign is124 = modePins inside {3'h1, 3'h2, 3'h4};
  assign busMode = is124 && (postRst >= 4'h8);

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      postRst <= 4'h0;
    else if (postRst != 4'hf)
      postRst <= postRst + 4'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer missing after one wait cycle");
  a_bus_refuse: assert property (read && !waitrequest
    && !(address inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10})
    |-> response == pfg_pkg::RESP_SLAVE_ERR && readdata == 32'h0)
    else $error("unmapped read not refused");
  a_dir_unread: assert property (read && !waitrequest && address == 5'h00
    |-> readdata == 32'h0)
    else $error("direction read leaks stored bits");
  a_pin7_reset: assert property (postRst == 4'h8 |-> pinOutEn_n[7] == !is124)
    else $error("pin 7 direction wrong after reset");
  a_pin7_clock: assert property (!pinOutEn_n[7]
    |-> pinOut[7] == $past(busStrobes.sysClockOut))
    else $error("pin 7 driven without the clock");
  a_read_strobe: assert property (busMode
    |-> !pinOutEn_n[5] && pinOut[5] == $past(busStrobes.readStrobe))
    else $error("pin 5 not the read strobe");
  a_high_write_strobe: assert property (busMode
    |-> !pinOutEn_n[4] && pinOut[4] == $past(busStrobes.highByteWriteStrobe))
    else $error("pin 4 not the high write strobe");
  a_wait_undriven: assert property (busMode && busSelect.waitEnable |=> pinOutEn_n[0])
    else $error("pin 0 driven while it is the wait input");
  a_wait_idle: assert property ((!busSelect.waitEnable) [*3] |-> busWait_n)
    else $error("wait asserted with the wait function off");

  cover property (read && !waitrequest && address == 5'h08);
  cover property (busMode && busSelect.waitEnable && !busWait_n);
  cover property (!pinOutEn_n[7] && pinOut[7]);
endmodule

bind pfg_port_f_gpio pfg_port_f_gpio_asserts u_chk
(
  .clock       (clock),
  .arst_n      (arst_n),
  .address     (address),
  .read        (read),
  .write       (write),
  .readdata    (readdata),
  .response    (response),
  .waitrequest (waitrequest),
  .modePins    (modePins),
  .busStrobes  (busStrobes),
  .busSelect   (busSelect),
  .pinOut      (pinOut),
  .pinOutEn_n  (pinOutEn_n),
  .busWait_n   (busWait_n)
);

// ==== pfg_pin_load.sv ====
`timescale 1ns/10ps
module pfg_pin_load
(
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOutEn_n,
  input  wire logic [7:0] extLevel,
  output logic      [7:0] pinIn
);
  // a driven pin reads back its own level, a released one follows the outside load
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pinIn[i] = pinOutEn_n[i] ? extLevel[i] : pinOut[i];
    end
  end
endmodule

// ==== tb_port_f_gpio_bus_pin_mux.sv ====
`timescale 1ns/10ps
module tb_port_f_gpio_bus_pin_mux;
  typedef struct packed {logic [7:0] dir, data, ext, en, st;} pfg_row_t;
  logic                     clock = 1'b0;
  logic                     arst_n = 1'b0;
  logic [4:0]               address = 5'h00;
  logic                     read = 1'b0;
  logic                     write = 1'b0;
  logic [31:0]              writedata = 32'h0;
  logic [31:0]              readdata;
  logic [31:0]              rd;
  logic [1:0]               response;
  logic [1:0]               rsp;
  logic                     waitrequest;
  logic [2:0]               modePins = 3'h7;
  pfg_pkg::pfg_strobes_t    busStrobes = 9'h100;
  pfg_pkg::pfg_bus_select_t busSelect = 2'h0;
  logic [7:0]               pinIn;
  logic [7:0]               pinOut;
  logic [7:0]               pinOutEn_n;
  logic [7:0]               extLevel = 8'h00;
  logic                     busWait_n;
  int                       fails = 0;
  int                       num_checks = 0;
  pfg_row_t rows [4] = '{'{8'hff, 8'ha5, 8'h00, 8'h00, 8'ha5},
                         '{8'h00, 8'hff, 8'h3c, 8'hff, 8'h3c},
                         '{8'h0f, 8'h5a, 8'hc3, 8'hf0, 8'hca},
                         '{8'h81, 8'h7e, 8'h18, 8'h7e, 8'h18}};

  always #12.5 clock = ~clock;

  pfg_port_f_gpio u_dut
  (
    .clock(clock), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .response(response),
    .waitrequest(waitrequest), .modePins(modePins), .busStrobes(busStrobes),
    .busSelect(busSelect), .pinIn(pinIn), .pinOut(pinOut), .pinOutEn_n(pinOutEn_n),
    .busWait_n(busWait_n)
  );

  pfg_pin_load u_load
  (
    .pinOut(pinOut), .pinOutEn_n(pinOutEn_n), .extLevel(extLevel), .pinIn(pinIn)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request stands until an edge sees waitrequest low; the answer is taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h0, d};
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge clock);
    end
    if (n >= 20)
    begin
      fails++;
    end
    rd = readdata;
    rsp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic pins(input logic [7:0] om, input logic [7:0] v, input logic [7:0] em,
                      input logic [7:0] en);
    repeat (3) @(posedge clock);
    chk(pinOut & om, v & om);
    chk(pinOutEn_n & em, en & em);
  endtask

  task automatic boot(input logic [2:0] m);
    arst_n <= 1'b0;
    modePins <= m;
    repeat (16) @(posedge clock);
    chk({busWait_n, pinOutEn_n, pinOut}, {1'b1, 8'hff, 8'h00});
    arst_n <= 1'b1;
    repeat (10) @(posedge clock);
  endtask

  task automatic end_of_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // whole run is under 3000 cycles, so this only fires on a hang
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    end_of_test();
  end

  initial
  begin
    boot(pfg_pkg::MODE_7);
    bus(1'b0, pfg_pkg::OFFSET_OUTPUT_DATA, 8'h00);
    chk(rd, 32'h0);
    pins(8'h00, 8'h00, 8'hff, 8'hff);
    foreach (rows[i])
    begin
      bus(1'b1, pfg_pkg::OFFSET_DIRECTION, rows[i].dir);
      bus(1'b1, pfg_pkg::OFFSET_OUTPUT_DATA, rows[i].data);
      extLevel <= rows[i].ext;
      pins(rows[i].dir & 8'h7f, rows[i].data, 8'hff, rows[i].en);
      bus(1'b0, pfg_pkg::OFFSET_PIN_STATE, 8'h00);
      chk(rd, {24'h0, rows[i].st});
    end
    bus(1'b1, pfg_pkg::OFFSET_PIN_STATE, 8'hff);
    bus(1'b0, pfg_pkg::OFFSET_PIN_STATE, 8'h00);
    chk(rd, 32'h18);
    bus(1'b0, pfg_pkg::OFFSET_DIRECTION, 8'h00);
    chk(rd, 32'h0);
    bus(1'b0, 5'h14, 8'h00);
    chk(rsp, pfg_pkg::RESP_SLAVE_ERR);
    bus(1'b1, pfg_pkg::OFFSET_DIRECTION, 8'h00);
    repeat (3) @(posedge clock);
    extLevel <= 8'hff;
    bus(1'b0, pfg_pkg::OFFSET_PIN_STATE, 8'h00);
    chk(rd, 32'h18);
    bus(1'b0, pfg_pkg::OFFSET_PIN_STATE, 8'h00);
    chk(rd, 32'hff);
    bus(1'b1, pfg_pkg::OFFSET_CONTROL, 8'h01);
    busStrobes.readStrobe <= 1'b1;
    pins(8'h30, 8'h20, 8'h79, 8'h49);
    bus(1'b1, pfg_pkg::OFFSET_CONTROL, 8'h07);
    busStrobes.addressStrobe <= 1'b1;
    busStrobes.lowByteWriteStrobe <= 1'b1;
    pins(8'h48, 8'h48, 8'h48, 8'h00);
    foreach (rows[i])
    begin
      if (i < 3)
      begin
        boot(i == 0 ? pfg_pkg::MODE_1 : i == 1 ? pfg_pkg::MODE_2 : pfg_pkg::MODE_4);
        pins(8'hc8, 8'hc8, 8'hc8, 8'h00);
        busSelect.columnStrobeSelect <= 1'b1;
        busStrobes.lowerColumnStrobe <= 1'b1;
        pins(8'h06, 8'h04, 8'h06, 8'h00);
        busSelect.columnStrobeSelect <= 1'b0;
        busStrobes.chipSelect6 <= 1'b1;
        bus(1'b1, pfg_pkg::OFFSET_CONTROL, 8'h08);
        pins(8'h04, 8'h04, 8'h4e, 8'h4a);
        busSelect.waitEnable <= 1'b1;
        extLevel <= 8'h00;
        pins(8'h00, 8'h00, 8'h01, 8'h01);
        // two sync stages plus the output flop: one edge more than the pin check
        @(posedge clock);
        chk(busWait_n, 1'b0);
        extLevel <= 8'h01;
        repeat (4) @(posedge clock);
        chk(busWait_n, 1'b1);
        busSelect.waitEnable <= 1'b0;
        bus(1'b1, pfg_pkg::OFFSET_DIRECTION, 8'h01);
        bus(1'b1, pfg_pkg::OFFSET_OUTPUT_DATA, 8'h01);
        pins(8'h01, 8'h01, 8'h01, 8'h00);
      end
    end
    end_of_test();
  end
endmodule
